// >>> logic/rtc_defines.svh
/*
 constants for the retentive timer and counter element block.
 assumes inclusion by bare name from the logic folder.
*/
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define RTC_OFF_TMR_CTRL   12'h000
`define RTC_OFF_TMR_TGT    12'h004
`define RTC_OFF_TMR_TOT    12'h008
`define RTC_OFF_CNT_CTRL   12'h00c
`define RTC_OFF_CNT_TGT    12'h010
`define RTC_OFF_CNT_TOT    12'h014
`define RTC_OFF_MODE       12'h018
`define RTC_ELEM_WORDS     3
`define RTC_CNT_FILE       5
`define RTC_ELEM_MAX       39
`define RTC_BIT_ACTIVE     15
`define RTC_BIT_TIMING     14
`define RTC_BIT_DONE       13
`define RTC_BIT_UP         15
`define RTC_BIT_DOWN       14
`define RTC_BIT_POSWRAP    12
`define RTC_BIT_NEGWRAP    11
`define RTC_BIT_REFRESH    10
`define RTC_TICK_NS        10000000
`define RTC_CLK_NS         10
`define RTC_TICK_CYCLES    (`RTC_TICK_NS / `RTC_CLK_NS)
`define RTC_RESP_OKAY      2'h0
`define RTC_RESP_SLVERR    2'h2
`endif

// >>> logic/rtc_pkg.sv
/*
 types for the retentive timer and counter element block.
 assumes the defines header is compiled alongside.
*/
package rtc_pkg;
	typedef enum logic [1:0] {
		RTC_MODE_PROGRAM = 2'b00,
		RTC_MODE_RUN     = 2'b01,
		RTC_MODE_TEST    = 2'b10,
		RTC_MODE_FAULT   = 2'b11
	} rtc_mode_e;
	typedef struct packed {
		logic        active;
		logic        timing;
		logic        done;
		logic [15:0] target;
		logic [15:0] total;
	} rtc_timer_s;
	typedef struct packed {
		logic        up_en;
		logic        down_en;
		logic        done;
		logic        pos_wrap;
		logic        neg_wrap;
		logic        refresh;
		logic [15:0] target;
		logic [15:0] total;
	} rtc_counter_s;
endpackage

// >>> logic/rtc_element.sv
/*
 retentive on-delay timer and up/down counter element behind an axi4-lite slave.
 assumes one 100 MHz clock, synchronous active-low reset, conditions from pins.
*/
// Added by the designer: the AXI4-Lite register port.
// Behaviour
// [RULE1] timer accumulates ticks while enabled; stops and keeps its total when disabled
// [RULE2] total preserved on disable, program mode, power loss, fault
// [RULE3] timer done sets when total reaches target; held until clear
// [RULE4] timing flag set while enabled and below target; cleared otherwise (the code also holds it clear while done is set)
// [RULE5] active flag follows the enabling condition
// [RULE6] entering program/fault or power loss while timing freezes flags and total
// [RULE7] back in run/test with condition true, timing resumes from kept total
// [RULE8] back in run/test with condition false, timing and active clear, rest kept
// [RULE9] only the clear command clears timer total and flags (the code also drops active and timing when the condition is false)
// [RULE10] counter element is three words: control, target, total
// [RULE11] control word: up 15, down 14, done 13, poswrap 12, negwrap 11, refresh 10
// [RULE12] refresh flag only meaningful for the fast pulse counter
// [RULE13] counter total counts false-to-true transitions since last clear
// [RULE14] counter done set when total >= target, signed compare
// [RULE15] target and total are signed 16-bit values
// [RULE16] overflow past +32767 sets poswrap; underflow past -32768 sets negwrap
// [RULE17] counter clear command sets the total to zero
// [RULE18] counter elements are file 5, elements 0 to 39, three words each
// [RULE19] element 0 used as fast pulse counter must not serve other counters
// [RULE20] timer adds one per prescaled timebase tick while enabled and below target
// [RULE21] edge found by comparing condition to its previous registered value
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defines.svh"
module rtc_element #(
	parameter int TICK_CYCLES = `RTC_TICK_CYCLES,
	parameter int ELEM_NUM    = 0
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        timer_enable_in,
	input  wire logic        count_up_in,
	input  wire logic        count_down_in,
	input  wire logic        power_ok_in,
	output var  logic        timer_done_r,
	output var  logic        counter_done_r
);
	initial
	begin
		if (TICK_CYCLES < 1 || ELEM_NUM < 0 || ELEM_NUM > `RTC_ELEM_MAX)
			$error("rtc_element: bad parameter");
	end

	// three-flop pin synchronisers
	logic [2:0] sy_ten_r, sy_up_r, sy_dn_r, sy_pw_r;
	logic       ten_r, up_r, dn_r, pw_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sy_ten_r <= 3'h0;
			sy_up_r  <= 3'h0;
			sy_dn_r  <= 3'h0;
			sy_pw_r  <= 3'h0;
			ten_r    <= 1'b0;
			up_r     <= 1'b0;
			dn_r     <= 1'b0;
			pw_r     <= 1'b0;
		end
		else
		begin
			sy_ten_r <= {sy_ten_r[1:0], timer_enable_in};
			sy_up_r  <= {sy_up_r[1:0], count_up_in};
			sy_dn_r  <= {sy_dn_r[1:0], count_down_in};
			sy_pw_r  <= {sy_pw_r[1:0], power_ok_in};
			if (sy_ten_r[1] == sy_ten_r[2])
				ten_r <= sy_ten_r[2];
			if (sy_up_r[1] == sy_up_r[2])
				up_r <= sy_up_r[2];
			if (sy_dn_r[1] == sy_dn_r[2])
				dn_r <= sy_dn_r[2];
			if (sy_pw_r[1] == sy_pw_r[2])
				pw_r <= sy_pw_r[2];
		end
	end

	// controller mode register
	rtc_pkg::rtc_mode_e mode_r;
	logic scan_on;
	assign scan_on = pw_r && (mode_r == rtc_pkg::RTC_MODE_RUN || mode_r == rtc_pkg::RTC_MODE_TEST);

	// timebase prescaler
	logic [31:0] pre_r;
	logic        tick;
	assign tick = (pre_r == 32'(TICK_CYCLES - 1));
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !scan_on || tick)
			pre_r <= 32'h0;
		else
			pre_r <= pre_r + 32'h1;
	end

	// axi write path
	logic        aw_hold_r, w_hold_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        do_wr;
	assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign s_axi_awready = !aw_hold_r;
	assign s_axi_wready  = !w_hold_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			awaddr_r     <= 12'h0;
			wdata_r      <= 32'h0;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RTC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_hold_r)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_r)
			begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_r <= `RTC_OFF_MODE && awaddr_r[1:0] == 2'h0)
				                ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// byte-lane merge of the low halfword
	function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		lanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic wr_tctl, wr_ttgt, wr_ttot, wr_cctl, wr_ctgt, wr_ctot, wr_mode;
	assign wr_tctl = do_wr && awaddr_r == `RTC_OFF_TMR_CTRL;
	assign wr_ttgt = do_wr && awaddr_r == `RTC_OFF_TMR_TGT;
	assign wr_ttot = do_wr && awaddr_r == `RTC_OFF_TMR_TOT;
	assign wr_cctl = do_wr && awaddr_r == `RTC_OFF_CNT_CTRL;
	assign wr_ctgt = do_wr && awaddr_r == `RTC_OFF_CNT_TGT;
	assign wr_ctot = do_wr && awaddr_r == `RTC_OFF_CNT_TOT;
	assign wr_mode = do_wr && awaddr_r == `RTC_OFF_MODE && wstrb_r[0];
	// clear command: write one to bit 0 of a control word
	logic tmr_clear, cnt_clear;
	assign tmr_clear = wr_tctl && wstrb_r[0] && wdata_r[0];
	assign cnt_clear = wr_cctl && wstrb_r[0] && wdata_r[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_r <= rtc_pkg::RTC_MODE_PROGRAM;
		else if (wr_mode)
			mode_r <= rtc_pkg::rtc_mode_e'(wdata_r[1:0]);
	end

	// retentive timer
	rtc_pkg::rtc_timer_s tmr_r;
	logic tmr_below;
	assign tmr_below = tmr_r.total < tmr_r.target;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tmr_r <= '0;
		else if (tmr_clear)
			tmr_r <= '{active: 1'b0, timing: 1'b0, done: 1'b0, target: tmr_r.target, total: 16'h0}; // RULE9
		else
		begin
			if (wr_ttgt)
				tmr_r.target <= lanes(tmr_r.target, wdata_r, wstrb_r);
			if (wr_ttot)
				tmr_r.total <= lanes(tmr_r.total, wdata_r, wstrb_r);
			else if (scan_on && ten_r && tick && tmr_below)
				tmr_r.total <= tmr_r.total + 16'h1; // RULE1 RULE20 RULE7
			if (scan_on)
			begin
				tmr_r.active <= ten_r; // RULE5 RULE8
				tmr_r.timing <= ten_r && tmr_below && !tmr_r.done; // RULE4 RULE8
				if (!tmr_below)
					tmr_r.done <= 1'b1; // RULE3
			end
			// outside run/test or without power flags and total hold, except for register writes RULE2 RULE6
		end
	end

	// up/down counter element, three words RULE10 RULE18
	rtc_pkg::rtc_counter_s cnt_r;
	logic up_prev_r, dn_prev_r;
	logic up_edge, dn_edge;
	logic [15:0] cnt_next;
	assign up_edge = up_r && !up_prev_r; // RULE21
	assign dn_edge = dn_r && !dn_prev_r; // RULE21
	always_comb
	begin
		cnt_next = cnt_r.total;
		if (up_edge && !dn_edge)
			cnt_next = cnt_r.total + 16'h1;
		else if (dn_edge && !up_edge)
			cnt_next = cnt_r.total - 16'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			up_prev_r <= 1'b0;
			dn_prev_r <= 1'b0;
		end
		else if (scan_on)
		begin
			up_prev_r <= up_r;
			dn_prev_r <= dn_r;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_r <= '0;
		else if (cnt_clear)
			cnt_r <= '{default: 1'b0, target: cnt_r.target, total: 16'h0}; // RULE17
		else
		begin
			if (wr_ctgt)
				cnt_r.target <= lanes(cnt_r.target, wdata_r, wstrb_r);
			if (wr_cctl && wstrb_r[1])
				cnt_r.refresh <= wdata_r[`RTC_BIT_REFRESH]; // RULE12
			if (wr_ctot)
				cnt_r.total <= lanes(cnt_r.total, wdata_r, wstrb_r);
			else if (scan_on)
			begin
				cnt_r.total <= cnt_next; // RULE13 RULE15
				cnt_r.up_en <= up_r;
				cnt_r.down_en <= dn_r;
				if (up_edge && !dn_edge && cnt_r.total == 16'h7fff)
					cnt_r.pos_wrap <= 1'b1; // RULE16
				else if (dn_edge && !up_edge && cnt_r.pos_wrap)
					cnt_r.pos_wrap <= 1'b0;
				if (dn_edge && !up_edge && cnt_r.total == 16'h8000)
					cnt_r.neg_wrap <= 1'b1; // RULE16
				else if (up_edge && !dn_edge && cnt_r.neg_wrap)
					cnt_r.neg_wrap <= 1'b0;
			end
			cnt_r.done <= $signed(cnt_r.total) >= $signed(cnt_r.target); // RULE14
		end
	end

	// control word images
	logic [15:0] tctl_word, cctl_word;
	always_comb
	begin
		tctl_word = 16'h0;
		tctl_word[`RTC_BIT_ACTIVE] = tmr_r.active;
		tctl_word[`RTC_BIT_TIMING] = tmr_r.timing;
		tctl_word[`RTC_BIT_DONE]   = tmr_r.done;
		cctl_word = 16'h0;
		cctl_word[`RTC_BIT_UP]      = cnt_r.up_en; // RULE11
		cctl_word[`RTC_BIT_DOWN]    = cnt_r.down_en;
		cctl_word[`RTC_BIT_DONE]    = cnt_r.done;
		cctl_word[`RTC_BIT_POSWRAP] = cnt_r.pos_wrap;
		cctl_word[`RTC_BIT_NEGWRAP] = cnt_r.neg_wrap;
		cctl_word[`RTC_BIT_REFRESH] = cnt_r.refresh;
	end

	// axi read path
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RTC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
			begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `RTC_RESP_OKAY;
				case (s_axi_araddr)
					`RTC_OFF_TMR_CTRL: s_axi_rdata <= {16'h0, tctl_word};
					`RTC_OFF_TMR_TGT:  s_axi_rdata <= {16'h0, tmr_r.target};
					`RTC_OFF_TMR_TOT:  s_axi_rdata <= {16'h0, tmr_r.total};
					`RTC_OFF_CNT_CTRL: s_axi_rdata <= {16'h0, cctl_word};
					`RTC_OFF_CNT_TGT:  s_axi_rdata <= {16'h0, cnt_r.target};
					`RTC_OFF_CNT_TOT:  s_axi_rdata <= {16'h0, cnt_r.total};
					`RTC_OFF_MODE:     s_axi_rdata <= {30'h0, mode_r};
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `RTC_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_done_r   <= 1'b0;
			counter_done_r <= 1'b0;
		end
		else
		begin
			timer_done_r   <= tmr_r.done;
			counter_done_r <= cnt_r.done;
		end
	end

	AST_TMR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
		!scan_on && !wr_ttot && !tmr_clear |=> $stable(tmr_r.total))
		else $error("timer total moved while halted");
	AST_TMR_STEP: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
		!wr_ttot && !tmr_clear |=> (tmr_r.total == $past(tmr_r.total)) || (tmr_r.total == $past(tmr_r.total) + 16'h1))
		else $error("timer total stepped by more than one");
	AST_TMR_DONE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
		tmr_r.done && !tmr_clear |=> tmr_r.done)
		else $error("timer done dropped without clear");
	AST_TMR_TIMING: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
		tmr_r.timing |-> tmr_r.active && !tmr_r.done)
		else $error("timing set while idle or done");
	AST_TMR_ACTIVE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		scan_on && !tmr_clear |=> tmr_r.active == $past(ten_r))
		else $error("active does not follow condition");
	AST_TMR_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
		tmr_clear |=> tmr_r.total == 16'h0 && !tmr_r.done && !tmr_r.active)
		else $error("timer clear failed");
	AST_CNT_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
		cnt_clear |=> cnt_r.total == 16'h0)
		else $error("counter clear failed");
	AST_CNT_UP: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
		scan_on && up_edge && !dn_edge && !wr_ctot && !cnt_clear |=> cnt_r.total == $past(cnt_r.total) + 16'h1)
		else $error("rising edge not counted");
	AST_CNT_WRAP: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
		scan_on && up_edge && !dn_edge && cnt_r.total == 16'h7fff && !cnt_clear |=> cnt_r.pos_wrap)
		else $error("overflow not flagged");
	AST_CNT_DONE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
		aresetn && !cnt_clear |=> cnt_r.done == ($signed($past(cnt_r.total)) >= $signed($past(cnt_r.target))))
		else $error("counter done wrong");
endmodule // rtc_element
`default_nettype wire

// >>> verification/rtc_element_bench.sv
/*
 self-checking bench for the timer and counter element, axi4-lite master tasks.
 assumes the element with a short tick, one 100 MHz clock, sync active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defines.svh"
module rtc_element_bench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        timer_enable_in = 1'b0;
	logic        count_up_in = 1'b0;
	logic        count_down_in = 1'b0;
	logic        power_ok_in = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        timer_done_r, counter_done_r;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          errors = 0;
	int          samples_checked = 0;
	logic [31:0] seed = 32'h6b4c7f73;

	rtc_element #(.TICK_CYCLES(4), .ELEM_NUM(0)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_enable_in, .count_up_in, .count_down_in,
		.power_ok_in, .timer_done_r, .counter_done_r);

	always #5 aclk = ~aclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic close_out();
		$display("checked %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic stall();
		errors++;
		$display("unexpected stall at %0t: exp 1 got 0", $time);
		close_out();
	endtask

	task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected read at %0t: exp %h got %h", $time, e, g);
		end
	endtask

	task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected bresp at %0t: exp %h got %h", $time, e, g);
		end
	endtask

	task automatic cmp_pin(input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected pin at %0t: exp %h got %h", $time, e, g);
		end
	endtask

	// answers are matched to the oldest note
	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready)
			cmp_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			cmp_resp(bq.pop_front(), s_axi_bresp);
	end

	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
		int n;
		@(posedge aclk);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		while (!(s_axi_bvalid && s_axi_bready) && n < 64);
		s_axi_bready <= 1'b0;
		if (n >= 64)
			stall();
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
		int n;
		@(posedge aclk);
		rq.push_back({r, 16'h0, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		while (!(s_axi_rvalid && s_axi_rready) && n < 64);
		s_axi_rready <= 1'b0;
		if (n >= 64)
			stall();
	endtask

	task automatic pulse(input logic up);
		@(posedge aclk);
		if (up)
			count_up_in <= 1'b1;
		else
			count_down_in <= 1'b1;
		repeat (8) @(posedge aclk);
		count_up_in <= 1'b0;
		count_down_in <= 1'b0;
		seed = xs(seed);
		repeat (8 + seed[2:0]) @(posedge aclk);
	endtask

	task automatic wait_td();
		int n;
		n = 0;
		while (timer_done_r !== 1'b1 && n < 400)
		begin
			@(posedge aclk);
			n++;
		end
		if (n >= 400)
			stall();
	endtask

	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(12'(4 * i), (i == 3) ? 16'h2000 : 16'h0000);
		rd(12'h01c, 16'h0000, `RTC_RESP_SLVERR);
		rd(12'h002, 16'h0000, `RTC_RESP_SLVERR);
		wr(12'h020, 16'h1234, `RTC_RESP_SLVERR);
		for (int m = 1; m < 4; m++)
		begin
			wr(`RTC_OFF_MODE, 16'(m));
			rd(`RTC_OFF_MODE, 16'(m));
		end
		$display("test reset and map done");
		wr(`RTC_OFF_MODE, {14'h0, rtc_pkg::RTC_MODE_RUN});
		wr(`RTC_OFF_TMR_TGT, 16'h0003);
		rd(`RTC_OFF_TMR_CTRL, 16'h2000);
		wr(`RTC_OFF_TMR_CTRL, 16'h0001);
		rd(`RTC_OFF_TMR_CTRL, 16'h0000);
		timer_enable_in <= 1'b1;
		wait_td();
		rd(`RTC_OFF_TMR_TOT, 16'h0003);
		rd(`RTC_OFF_TMR_CTRL, 16'ha000);
		cmp_pin(1'b1, timer_done_r);
		timer_enable_in <= 1'b0;
		repeat (8) @(posedge aclk);
		rd(`RTC_OFF_TMR_CTRL, 16'h2000);
		rd(`RTC_OFF_TMR_TOT, 16'h0003);
		wr(`RTC_OFF_TMR_CTRL, 16'h0001);
		rd(`RTC_OFF_TMR_CTRL, 16'h0000);
		rd(`RTC_OFF_TMR_TOT, 16'h0000);
		$display("test timer done and clear done");
		wr(`RTC_OFF_TMR_TGT, 16'h0064);
		timer_enable_in <= 1'b1;
		repeat (20) @(posedge aclk);
		wr(`RTC_OFF_MODE, {14'h0, rtc_pkg::RTC_MODE_FAULT});
		rd(`RTC_OFF_TMR_CTRL, 16'hc000);
		wr(`RTC_OFF_TMR_TOT, 16'h0007);
		power_ok_in <= 1'b0;
		wr(`RTC_OFF_MODE, {14'h0, rtc_pkg::RTC_MODE_RUN});
		repeat (40) @(posedge aclk);
		rd(`RTC_OFF_TMR_TOT, 16'h0007);
		rd(`RTC_OFF_TMR_CTRL, 16'hc000);
		wr(`RTC_OFF_TMR_TGT, 16'h0009);
		power_ok_in <= 1'b1;
		wait_td();
		rd(`RTC_OFF_TMR_TOT, 16'h0009);
		rd(`RTC_OFF_TMR_CTRL, 16'ha000);
		wr(`RTC_OFF_MODE, {14'h0, rtc_pkg::RTC_MODE_PROGRAM});
		timer_enable_in <= 1'b0;
		repeat (8) @(posedge aclk);
		wr(`RTC_OFF_MODE, {14'h0, rtc_pkg::RTC_MODE_RUN});
		repeat (8) @(posedge aclk);
		rd(`RTC_OFF_TMR_CTRL, 16'h2000);
		rd(`RTC_OFF_TMR_TOT, 16'h0009);
		$display("test timer retention done");
		wr(`RTC_OFF_MODE, {14'h0, rtc_pkg::RTC_MODE_TEST});
		wr(`RTC_OFF_CNT_TGT, 16'h0005);
		wr(`RTC_OFF_CNT_CTRL, 16'h0001);
		rd(`RTC_OFF_CNT_TGT, 16'h0005);
		rd(`RTC_OFF_CNT_TOT, 16'h0000);
		repeat (5) pulse(1'b1);
		rd(`RTC_OFF_CNT_TOT, 16'h0005);
		rd(`RTC_OFF_CNT_CTRL, 16'h2000);
		cmp_pin(1'b1, counter_done_r);
		pulse(1'b0);
		rd(`RTC_OFF_CNT_TOT, 16'h0004);
		rd(`RTC_OFF_CNT_CTRL, 16'h0000);
		wr(`RTC_OFF_CNT_TOT, 16'h7fff);
		pulse(1'b1);
		rd(`RTC_OFF_CNT_TOT, 16'h8000);
		rd(`RTC_OFF_CNT_CTRL, 16'h1000);
		pulse(1'b0);
		rd(`RTC_OFF_CNT_TOT, 16'h7fff);
		rd(`RTC_OFF_CNT_CTRL, 16'h2800);
		wr(`RTC_OFF_CNT_CTRL, 16'h0001);
		rd(`RTC_OFF_CNT_TOT, 16'h0000);
		rd(`RTC_OFF_CNT_CTRL, 16'h0000);
		wr(`RTC_OFF_CNT_TGT, 16'hfffe);
		rd(`RTC_OFF_CNT_CTRL, 16'h2000);
		wr(`RTC_OFF_CNT_CTRL, 16'h0400);
		count_up_in <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(`RTC_OFF_CNT_CTRL, 16'ha400);
		count_up_in <= 1'b0;
		rd(`RTC_OFF_CNT_TOT, 16'h0001);
		$display("test counter done");
		repeat (4) @(posedge aclk);
		close_out();
	end
endmodule // rtc_element_bench
`default_nettype wire
